// ==== hdl/fprl_pkg.sv ====
// package: register map, field layout and constants of the fan ramp limiter
package fprl_pkg;
  localparam int NCH = 3;
  localparam logic [7:0] ADDR_DRV1 = 8'h5C;
  localparam logic [7:0] ADDR_DRV2 = 8'h5D;
  localparam logic [7:0] ADDR_DRV3 = 8'h5E;
  localparam logic [7:0] ADDR_ACOU1 = 8'h62;
  localparam logic [7:0] ADDR_RAMP_SEL_CH2 = 8'h63;
  localparam logic [7:0] ADDR_DUTY1 = 8'h30;
  localparam logic [7:0] ADDR_DUTY2 = 8'h31;
  localparam logic [7:0] ADDR_DUTY3 = 8'h32;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam int SLOW_BIT = 3;
  localparam int EN1_BIT = 3;
  localparam int EN2_BIT = 7;
  localparam int EN3_BIT = 3;
  localparam int SEL_LO_POS = 0;
  localparam int SEL_HI_POS = 4;
  localparam logic [7:0] PWM_SLOTS = 8'hFF;
  localparam logic [1:0] SLOW_DIV_LAST = 2'h3;
  localparam int SLOT_CYCLES = 1;
  typedef struct packed {
    logic en;
    logic slow;
    logic [2:0] sel;
  } fprl_chcfg_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } fprl_bus_t;
  // step sizes per ramp select code
  function automatic logic [7:0] step_of(input logic [2:0] code);
    logic [7:0] s;
    s = 8'h01;
    unique case (code)
      3'h0: s = 8'h01;
      3'h1: s = 8'h02;
      3'h2: s = 8'h03;
      3'h3: s = 8'h05;
      3'h4: s = 8'h08;
      3'h5: s = 8'h0C;
      3'h6: s = 8'h18;
      3'h7: s = 8'h30;
    endcase
    return s;
  endfunction
endpackage

// ==== hdl/fprl_ramp_step.sv ====
// one channel: ramp limiter on the applied duty
`timescale 1ns/1ns
`default_nettype none
module fprl_ramp_step (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // configuration and update
  input wire fprl_pkg::fprl_chcfg_t cfg,
  input wire logic update,
  input wire logic [7:0] target,
  // applied duty
  output logic [7:0] duty
);
  logic [7:0] duty_reg, duty_next;
  logic [1:0] div_reg, div_next;
  logic [7:0] step;
  logic [7:0] up_gap, dn_gap;
  logic take;
  logic [7:0] ramped;

  // step select and gaps to target
  assign step = fprl_pkg::step_of(cfg.sel);
  assign up_gap = target - duty_reg;
  assign dn_gap = duty_reg - target;
  // slowed channels with limiting enabled act on every fourth update only
  assign take = update && (!cfg.slow || div_reg == fprl_pkg::SLOW_DIV_LAST);
  assign div_next = update ? div_reg + 2'h1 : div_reg;
  assign ramped = (target > duty_reg) ? ((up_gap < step) ? target : duty_reg + step)
                : (target < duty_reg) ? ((dn_gap < step) ? target : duty_reg - step)
                : duty_reg;
  assign duty_next = !cfg.en ? (update ? target : duty_reg)
                   : (take ? ramped : duty_reg);
  assign duty = duty_reg;

  // applied duty and slow divider
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      duty_reg <= fprl_pkg::REG_RESET;
      div_reg <= '0;
    end else begin
      duty_reg <= duty_next;
      div_reg <= div_next;
    end
  end

  ramp_bound_a: assert property (@(posedge clock) disable iff (!rst_n)
    (update && cfg.en && !cfg.slow && target > duty_reg) |=> (duty_reg - $past(duty_reg)) <= $past(step))
    else $error("ramp step exceeded");
  follow_off_a: assert property (@(posedge clock) disable iff (!rst_n)
    (update && !cfg.en) |=> duty_reg == $past(target))
    else $error("disabled channel did not follow target");
  hold_idle_a: assert property (@(posedge clock) disable iff (!rst_n)
    !update |=> $stable(duty_reg))
    else $error("duty moved without update");
  down_move_a: assert property (@(posedge clock) disable iff (!rst_n)
    (take && cfg.en && target < duty_reg) |=> duty_reg < $past(duty_reg) && duty_reg >= $past(target))
    else $error("ramp down wrong");
  equal_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
    (update && cfg.en && target == duty_reg) |=> duty_reg == $past(target))
    else $error("equal target not held");
  slow_skip_a: assert property (@(posedge clock) disable iff (!rst_n)
    (update && cfg.en && cfg.slow && div_reg != fprl_pkg::SLOW_DIV_LAST) |=> $stable(duty_reg))
    else $error("slowed channel stepped off its turn");
endmodule
`default_nettype wire

// ==== hdl/fprl_pwm_out.sv ====
// one channel: 255-slot pwm waveform from the applied duty
`timescale 1ns/1ns
`default_nettype none
module fprl_pwm_out (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // slot tick and duty
  input wire logic slot_tick,
  input wire logic [7:0] duty,
  // pwm pin
  output logic pwm
);
  logic [7:0] slot_reg, slot_next;
  logic [7:0] duty_reg, duty_next;
  logic pwm_reg, pwm_next;
  logic wrap;

  // slot counter 0..254, duty latched at the start of a period
  assign wrap = slot_reg == fprl_pkg::PWM_SLOTS - 8'h01;
  assign slot_next = !slot_tick ? slot_reg : (wrap ? 8'h00 : slot_reg + 8'h01);
  assign duty_next = (slot_tick && wrap) ? duty : duty_reg;
  assign pwm_next = slot_next < duty_next;
  assign pwm = pwm_reg;

  // counter and output flops
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      slot_reg <= '0;
      duty_reg <= '0;
      pwm_reg <= 1'b0;
    end else begin
      slot_reg <= slot_next;
      duty_reg <= duty_next;
      pwm_reg <= pwm_next;
    end
  end

  slot_wrap_a: assert property (@(posedge clock) disable iff (!rst_n)
    (slot_tick && wrap) |=> slot_reg == 8'h00)
    else $error("slot counter did not wrap at 255");
endmodule
`default_nettype wire

// ==== hdl/fprl_top.sv ====
// top: register file, three ramp limiters and three pwm outputs
`timescale 1ns/1ns
`default_nettype none
module fprl_top #(
  parameter int SLOT_DIV = fprl_pkg::SLOT_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rdata,
  // temperature loop: new targets per measurement
  input wire logic temp_update,
  input wire logic [23:0] target_duty,
  // fan pins
  output logic [2:0] pwm_out
);
  logic [7:0] drv_reg [fprl_pkg::NCH];
  logic [7:0] acou1_reg, ramp_sel_ch2_reg;
  logic [7:0] rdata_reg, rdata_next;
  logic [7:0] duty [fprl_pkg::NCH];
  logic [15:0] tick_reg, tick_next;
  logic slot_tick;
  fprl_pkg::fprl_chcfg_t cfg [fprl_pkg::NCH];
  logic wr_a1, wr_a2;
  logic [2:0] wr_drv;

  // write decode
  assign wr_a1 = wr_stb && addr == fprl_pkg::ADDR_ACOU1;
  assign wr_a2 = wr_stb && addr == fprl_pkg::ADDR_RAMP_SEL_CH2;
  assign wr_drv[0] = wr_stb && addr == fprl_pkg::ADDR_DRV1;
  assign wr_drv[1] = wr_stb && addr == fprl_pkg::ADDR_DRV2;
  assign wr_drv[2] = wr_stb && addr == fprl_pkg::ADDR_DRV3;

  // per-channel field extraction
  assign cfg[0].en = acou1_reg[fprl_pkg::EN1_BIT];
  assign cfg[1].en = ramp_sel_ch2_reg[fprl_pkg::EN2_BIT];
  assign cfg[2].en = ramp_sel_ch2_reg[fprl_pkg::EN3_BIT];
  assign cfg[0].sel = acou1_reg[fprl_pkg::SEL_LO_POS +: 3];
  assign cfg[1].sel = ramp_sel_ch2_reg[fprl_pkg::SEL_HI_POS +: 3];
  assign cfg[2].sel = ramp_sel_ch2_reg[fprl_pkg::SEL_LO_POS +: 3];
  assign cfg[0].slow = drv_reg[0][fprl_pkg::SLOW_BIT];
  assign cfg[1].slow = drv_reg[1][fprl_pkg::SLOW_BIT];
  assign cfg[2].slow = drv_reg[2][fprl_pkg::SLOW_BIT];

  // read mux, data stands one cycle after the strobe
  assign rdata_next = !rd_stb ? fprl_pkg::UNMAPPED_READ
    : addr == fprl_pkg::ADDR_ACOU1 ? acou1_reg
    : addr == fprl_pkg::ADDR_RAMP_SEL_CH2 ? ramp_sel_ch2_reg
    : addr == fprl_pkg::ADDR_DRV1 ? drv_reg[0]
    : addr == fprl_pkg::ADDR_DRV2 ? drv_reg[1]
    : addr == fprl_pkg::ADDR_DRV3 ? drv_reg[2]
    : addr == fprl_pkg::ADDR_DUTY1 ? duty[0]
    : addr == fprl_pkg::ADDR_DUTY2 ? duty[1]
    : addr == fprl_pkg::ADDR_DUTY3 ? duty[2]
    : fprl_pkg::UNMAPPED_READ;
  assign rdata = rdata_reg;

  // slot tick prescaler
  assign slot_tick = tick_reg == 16'(SLOT_DIV - 1);
  assign tick_next = slot_tick ? 16'h0000 : tick_reg + 16'h0001;

  // control registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      acou1_reg <= fprl_pkg::REG_RESET;
      ramp_sel_ch2_reg <= fprl_pkg::REG_RESET;
      rdata_reg <= fprl_pkg::REG_RESET;
      tick_reg <= '0;
    end else begin
      if (wr_a1) acou1_reg <= wdata;
      if (wr_a2) ramp_sel_ch2_reg <= wdata;
      rdata_reg <= rdata_next;
      tick_reg <= tick_next;
    end
  end

  // per-channel drive config, limiter and pwm
  genvar i;
  generate
    for (i = 0; i < fprl_pkg::NCH; i++) begin : g_ch
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          drv_reg[i] <= fprl_pkg::REG_RESET;
        end else if (wr_drv[i]) begin
          drv_reg[i] <= wdata;
        end
      end
      // target recomputed upstream each measurement
      fprl_ramp_step u_ramp (
        .clock(clock),
        .rst_n(rst_n),
        .cfg(cfg[i]),
        .update(temp_update),
        .target(target_duty[i*8 +: 8]),
        .duty(duty[i])
      );
      fprl_pwm_out u_pwm (
        .clock(clock),
        .rst_n(rst_n),
        .slot_tick(slot_tick),
        .duty(duty[i]),
        .pwm(pwm_out[i])
      );
    end
  endgenerate

  read_data_a: assert property (@(posedge clock) disable iff (!rst_n)
    (rd_stb && addr == fprl_pkg::ADDR_RAMP_SEL_CH2) |=> rdata == $past(ramp_sel_ch2_reg))
    else $error("read data wrong");
  sel_map_a: assert property (@(posedge clock) disable iff (!rst_n)
    wr_a2 |=> cfg[1].sel == $past(wdata[fprl_pkg::SEL_HI_POS +: 3]))
    else $error("channel 2 select misplaced");
  en_map_a: assert property (@(posedge clock) disable iff (!rst_n)
    (wr_a1) |=> cfg[0].en == $past(wdata[fprl_pkg::EN1_BIT]))
    else $error("channel 1 enable not taken");
  en2_map_a: assert property (@(posedge clock) disable iff (!rst_n)
    wr_a2 |=> cfg[1].en == $past(wdata[fprl_pkg::EN2_BIT]))
    else $error("channel 2 enable not taken");
  en3_map_a: assert property (@(posedge clock) disable iff (!rst_n)
    wr_a2 |=> cfg[2].en == $past(wdata[fprl_pkg::EN3_BIT]))
    else $error("channel 3 enable not taken");
  sel1_map_a: assert property (@(posedge clock) disable iff (!rst_n)
    wr_a1 |=> cfg[0].sel == $past(wdata[fprl_pkg::SEL_LO_POS +: 3]))
    else $error("channel 1 select misplaced");
  sel3_map_a: assert property (@(posedge clock) disable iff (!rst_n)
    wr_a2 |=> cfg[2].sel == $past(wdata[fprl_pkg::SEL_LO_POS +: 3]))
    else $error("channel 3 select misplaced");
  slow_map_a: assert property (@(posedge clock) disable iff (!rst_n)
    wr_drv[1] |=> cfg[1].slow == $past(wdata[fprl_pkg::SLOW_BIT]))
    else $error("channel 2 slow bit not taken");
  duty_read_a: assert property (@(posedge clock) disable iff (!rst_n)
    (rd_stb && addr == fprl_pkg::ADDR_DUTY3) |=> rdata == $past(duty[2]))
    else $error("applied duty read wrong");
  read_idle_a: assert property (@(posedge clock) disable iff (!rst_n)
    !rd_stb |=> rdata == fprl_pkg::UNMAPPED_READ)
    else $error("read data did not return to zero");
endmodule
`default_nettype wire

// ==== test/fprl_fan_model.sv ====
// fan model: measures the high slots of each 255-slot pwm window
`timescale 1ns/1ns
`default_nettype none
module fprl_fan_model (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // pwm pin and measured duty
  input wire logic pwm,
  output logic [7:0] seen_duty
);
  logic [7:0] slot_reg;
  logic [7:0] high_reg;
  // one slot per clock, so any 255 cycles of a steady duty hold duty highs
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      slot_reg <= 8'h00;
      high_reg <= 8'h00;
      seen_duty <= 8'h00;
    end else if (slot_reg == 8'hFE) begin
      slot_reg <= 8'h00;
      high_reg <= 8'h00;
      seen_duty <= high_reg + {7'h00, pwm};
    end else begin
      slot_reg <= slot_reg + 8'h01;
      high_reg <= high_reg + {7'h00, pwm};
    end
  end
endmodule
`default_nettype wire

// ==== test/fan_pwm_ramp_limiter_bench.sv ====
// bench: register access, ramp stepping, slow-down and pwm waveform
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module fan_pwm_ramp_limiter_bench;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic temp_update = 1'b0;
  logic [23:0] target_duty = 24'h000000;
  logic [7:0] rdata;
  logic [2:0] pwm_out;
  logic [23:0] fan_duty;
  int n_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [7:0] steps [8] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h08, 8'h0C, 8'h18, 8'h30};
  logic [7:0] regs [9] = '{8'h5C, 8'h5D, 8'h5E, 8'h62, 8'h63, 8'h30, 8'h31, 8'h32, 8'h40};
  fprl_top #(.SLOT_DIV(1)) dut_u (.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .temp_update(temp_update),
    .target_duty(target_duty), .pwm_out(pwm_out));
  fprl_fan_model fan_u [2:0] (.clock(clock), .rst_n(rst_n), .pwm(pwm_out),
    .seen_duty(fan_duty));
  // clock and hang guard
  initial forever #5 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clock);
    wr_stb <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clock);
    rd_stb <= 1'b0;
    #1;
    `CHK(rdata, e)
    @(posedge clock);
    #1;
    `CHK(rdata, 8'h00)
  endtask
  task automatic upd(input logic [23:0] t);
    @(posedge clock);
    temp_update <= 1'b1;
    target_duty <= t;
    @(posedge clock);
    temp_update <= 1'b0;
  endtask
  // reset values, unmapped read, read-only duty write
  task automatic t_reset;
    foreach (regs[i]) chk_rd(regs[i], 8'h00);
    wr(8'h30, 8'hAA);
    chk_rd(8'h30, 8'h00);
  endtask
  // limiting off: duty follows target, fans see it as slots
  task automatic t_follow;
    upd(24'h00FF55);
    chk_rd(8'h30, 8'h55);
    chk_rd(8'h31, 8'hFF);
    repeat (800) @(posedge clock);
    `CHK(fan_duty, 24'h00FF55)
  endtask
  // every ramp code on channel 1, up then down
  task automatic t_codes;
    for (int c = 0; c < 8; c++) begin
      wr(8'h62, 8'h00);
      upd(24'h000000);
      wr(8'h62, 8'h08 | 8'(c));
      upd(24'h0000C8);
      chk_rd(8'h30, steps[c]);
      upd(24'h000000);
      chk_rd(8'h30, 8'h00);
    end
  endtask
  // channel 2 and 3 fields, repeated steps
  task automatic t_fields;
    wr(8'h63, 8'hBD);
    chk_rd(8'h63, 8'hBD);
    upd(24'h646464);
    chk_rd(8'h31, 8'h05);
    chk_rd(8'h32, 8'h0C);
    upd(24'h646464);
    chk_rd(8'h31, 8'h0A);
    chk_rd(8'h32, 8'h18);
  endtask
  // gap below step closes exactly, then holds
  task automatic t_gap;
    wr(8'h62, 8'h00);
    upd(24'h000000);
    wr(8'h62, 8'h0F);
    upd(24'h00001E);
    chk_rd(8'h30, 8'h1E);
    upd(24'h00001E);
    chk_rd(8'h30, 8'h1E);
  endtask
  // fastest code: a full-scale climb takes six updates
  task automatic t_full;
    wr(8'h62, 8'h00);
    upd(24'h000000);
    wr(8'h62, 8'h0F);
    repeat (5) upd(24'h0000FF);
    chk_rd(8'h30, 8'hF0);
    upd(24'h0000FF);
    chk_rd(8'h30, 8'hFF);
  endtask
  // slow-down: one step in any four updates
  task automatic t_slow;
    wr(8'h62, 8'h00);
    upd(24'h000000);
    wr(8'h62, 8'h08);
    wr(8'h5C, 8'h08);
    wr(8'h5D, 8'h08);
    wr(8'h5E, 8'h08);
    chk_rd(8'h5C, 8'h08);
    chk_rd(8'h5E, 8'h08);
    repeat (4) upd(24'hC8C8C8);
    chk_rd(8'h30, 8'h01);
    chk_rd(8'h31, 8'h05);
    chk_rd(8'h32, 8'h0C);
    repeat (4) upd(24'hC8C8C8);
    chk_rd(8'h30, 8'h02);
    chk_rd(8'h31, 8'h0A);
    chk_rd(8'h32, 8'h18);
  endtask
  task automatic tally_and_finish;
    $display("checks_done=%0d n_errors=%0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_follow();
    t_codes();
    t_fields();
    t_gap();
    t_full();
    t_slow();
    tally_and_finish();
  end
endmodule
`default_nettype wire
